// file: hw/anpr_dec_if.sv
// Carrier between the top and the address decoder.
`timescale 1ns/1ps
`default_nettype none
interface anpr_dec_if;
   logic [4:0] addr;
   anpr_pkg::anpr_sel_type sel;
   logic [2:0] ps_index;
   modport top (output addr, input sel, input ps_index);
   modport dec (input addr, output sel, output ps_index);
endinterface
`default_nettype wire

// file: hw/anpr_decode.sv
// Register address decoder for the next page bank and product-specific map.
`timescale 1ns/1ps
`default_nettype none
`include "anpr_params.svh"
module anpr_decode (
   anpr_dec_if.dec bus // Address in, selection out.
);
   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   wire logic is_ps;
   assign is_ps = (bus.addr == `ANPR_ADDR_PORT_CFG) || (bus.addr == `ANPR_ADDR_STATUS2)
      || (bus.addr == `ANPR_ADDR_INT_EN) || (bus.addr == `ANPR_ADDR_STAT_CHG)
      || (bus.addr == `ANPR_ADDR_LED_CFG) || (bus.addr == `ANPR_ADDR_DIG_CFG)
      || (bus.addr == `ANPR_ADDR_TX_CTRL);
   assign bus.sel = (bus.addr == `ANPR_ADDR_PAGE_TX) ? anpr_pkg::ANPR_SEL_TX :
      (bus.addr == `ANPR_ADDR_PAGE_RX) ? anpr_pkg::ANPR_SEL_RX :
      (bus.addr == `ANPR_ADDR_EXPANSION) ? anpr_pkg::ANPR_SEL_EXP :
      is_ps ? anpr_pkg::ANPR_SEL_PS : anpr_pkg::ANPR_SEL_NONE;
   // Index 0..6 in table order; reserved addresses give 7.
   assign bus.ps_index = (bus.addr == `ANPR_ADDR_PORT_CFG) ? 3'h0 :
      (bus.addr == `ANPR_ADDR_STATUS2) ? 3'h1 :
      (bus.addr == `ANPR_ADDR_INT_EN) ? 3'h2 :
      (bus.addr == `ANPR_ADDR_STAT_CHG) ? 3'h3 :
      (bus.addr == `ANPR_ADDR_LED_CFG) ? 3'h4 :
      (bus.addr == `ANPR_ADDR_DIG_CFG) ? 3'h5 :
      (bus.addr == `ANPR_ADDR_TX_CTRL) ? 3'h6 : 3'h7;
endmodule // anpr_decode
`default_nettype wire

// file: hw/anpr_params.svh
// Constants for the auto-negotiation next page register bank.
// What this block does
// - Outgoing bit 15 writable, reset 0; 1 means more next pages follow.
// - Outgoing bit 13 writable, reset 1; selects message code or user data.
// - Outgoing bit 12 writable acknowledge-two flag, reset 0.
// - Outgoing bit 11 writable toggle bit, reset 0.
// - Outgoing bits 10:0 writable code field, reset to 1.
// - Received word read-only, resets to zero; bit 15 is partner more-pages.
// - Received bit 14 shows partner acknowledge of local code word.
// - Received bit 13 shows partner message page select.
// - Received bit 12 shows partner acknowledge-two.
// - Received bit 11 shows partner toggle bit.
// - Received bits 10:0 hold partner code field, reset zero.
// - Addresses 16-20, 26, 30 decode to product registers; others except 6-8 reserved.
// - New next page loads received word and sets latching flag, cleared on read.
`ifndef ANPR_PARAMS_SVH
`define ANPR_PARAMS_SVH
// ----------------------------------------------------------------
// Addresses
// ----------------------------------------------------------------
`define ANPR_ADDR_EXPANSION 5'h06
`define ANPR_ADDR_PAGE_TX 5'h07
`define ANPR_ADDR_PAGE_RX 5'h08
`define ANPR_ADDR_PORT_CFG 5'h10
`define ANPR_ADDR_STATUS2 5'h11
`define ANPR_ADDR_INT_EN 5'h12
`define ANPR_ADDR_STAT_CHG 5'h13
`define ANPR_ADDR_LED_CFG 5'h14
`define ANPR_ADDR_DIG_CFG 5'h1A
`define ANPR_ADDR_TX_CTRL 5'h1E
// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define ANPR_BIT_MORE 15
`define ANPR_BIT_RSVD 14
`define ANPR_BIT_MSG 13
`define ANPR_BIT_ACK_TWO 12
`define ANPR_BIT_TOG 11
`define ANPR_CODE_MSB 10
`define ANPR_TX_RESET 16'h2001
`define ANPR_RX_RESET 16'h0000
`define ANPR_TX_WMASK 16'hBFFF
`define ANPR_PAGE_RX_BIT 1
`endif

// file: hw/anpr_pkg.sv
// Types for the auto-negotiation next page register bank.
package anpr_pkg;
   typedef enum logic [3:0] {
      ANPR_SEL_NONE = 4'h0,
      ANPR_SEL_TX = 4'h1,
      ANPR_SEL_RX = 4'h2,
      ANPR_SEL_PS = 4'h3,
      ANPR_SEL_EXP = 4'h4
   } anpr_sel_type;
endpackage

// file: hw/anpr_regs.sv
// Auto-negotiation next page transmit and receive registers with address decode.
`timescale 1ns/1ps
`default_nettype none
`include "anpr_params.svh"
module anpr_regs (
   input wire logic i_clock, // Management clock, 25 MHz.
   input wire logic i_rstn, // Asynchronous reset, active low.
   input wire logic [4:0] i_reg_addr, // Register address from serial interface.
   input wire logic i_reg_wr, // One-cycle write strobe.
   input wire logic i_reg_rd, // One-cycle read strobe.
   input wire logic [15:0] i_reg_wdata, // Write data.
   output logic [15:0] o_reg_rdata, // Read data, registered.
   output logic o_ps_wr, // Write strobe to a product-specific register.
   output logic o_ps_rd, // Read strobe to a product-specific register.
   output logic [2:0] o_ps_index, // Product-specific register index.
   input wire logic [15:0] i_ps_rdata, // Product-specific read data.
   input wire logic i_page_rx_valid, // One-cycle pulse: partner next page arrived.
   input wire logic [15:0] i_page_rx_word, // Partner link code word.
   input wire logic i_page_tx_taken, // One-cycle pulse: arbiter sent the outgoing word.
   output logic [15:0] o_page_tx_word, // Outgoing link code word, registered.
   output logic o_page_tx_ready, // Outgoing word written since last send.
   output logic o_page_received // Latching page-received flag.
);
   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   anpr_dec_if dec ();
   assign dec.addr = i_reg_addr;
   anpr_decode u_decode (
      .bus (dec)
   );
   wire logic wr_tx;
   wire logic rd_rx_sel;
   wire logic rd_exp;
   assign wr_tx = i_reg_wr && (dec.sel == anpr_pkg::ANPR_SEL_TX);
   assign rd_exp = i_reg_rd && (dec.sel == anpr_pkg::ANPR_SEL_EXP);
   assign rd_rx_sel = (dec.sel == anpr_pkg::ANPR_SEL_RX);
   assign o_ps_wr = i_reg_wr && (dec.sel == anpr_pkg::ANPR_SEL_PS);
   assign o_ps_rd = i_reg_rd && (dec.sel == anpr_pkg::ANPR_SEL_PS);
   assign o_ps_index = dec.ps_index;
   // ----------------------------------------------------------------
   // Outgoing next page word
   // ----------------------------------------------------------------
   // Bit 14 is masked off so it can never be stored and always reads 0.
   logic [15:0] tx_r;
   logic [15:0] tx_nxt;
   assign tx_nxt = wr_tx ? (i_reg_wdata & `ANPR_TX_WMASK) : tx_r;
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         tx_r <= `ANPR_TX_RESET;
      end else begin
         tx_r <= tx_nxt;
      end
   end
   assign o_page_tx_word = tx_r;
   // A fresh write arms the word; a send disarms it. A write in the send cycle wins.
   logic ready_r;
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         ready_r <= 1'b0;
      end else if (wr_tx) begin
         ready_r <= 1'b1;
      end else if (i_page_tx_taken) begin
         ready_r <= 1'b0;
      end
   end
   assign o_page_tx_ready = ready_r;
   // ----------------------------------------------------------------
   // Received next page word and page-received flag
   // ----------------------------------------------------------------
   logic [15:0] rx_r;
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         rx_r <= `ANPR_RX_RESET;
      end else if (i_page_rx_valid) begin
         rx_r <= i_page_rx_word;
      end
   end
   // Arrival in the reading cycle keeps the flag set, so no page is missed.
   logic flag_r;
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         flag_r <= 1'b0;
      end else if (i_page_rx_valid) begin
         flag_r <= 1'b1;
      end else if (rd_exp) begin
         flag_r <= 1'b0;
      end
   end
   assign o_page_received = flag_r;
   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   wire logic [15:0] exp_word;
   wire logic [15:0] rd_mux;
   assign exp_word = {14'h0000, flag_r, 1'b0};
   assign rd_mux = (dec.sel == anpr_pkg::ANPR_SEL_TX) ? tx_r :
      rd_rx_sel ? rx_r :
      (dec.sel == anpr_pkg::ANPR_SEL_EXP) ? exp_word :
      (dec.sel == anpr_pkg::ANPR_SEL_PS) ? i_ps_rdata : 16'h0000;
   logic [15:0] rdata_r;
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         rdata_r <= 16'h0000;
      end else if (i_reg_rd) begin
         rdata_r <= rd_mux;
      end
   end
   assign o_reg_rdata = rdata_r;
   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_tx_rsvd_zero: assert property (@(posedge i_clock) disable iff (!i_rstn)
      tx_r[`ANPR_BIT_RSVD] == 1'b0) else $error("reserved outgoing bit set");
   a_tx_write_load: assert property (@(posedge i_clock) disable iff (!i_rstn)
      wr_tx |=> (o_page_tx_word == ($past(i_reg_wdata) & `ANPR_TX_WMASK)))
      else $error("outgoing word not loaded");
   a_tx_hold: assert property (@(posedge i_clock) disable iff (!i_rstn)
      !wr_tx |=> $stable(o_page_tx_word)) else $error("outgoing word changed");
   a_rx_capture: assert property (@(posedge i_clock) disable iff (!i_rstn)
      i_page_rx_valid |=> (rx_r == $past(i_page_rx_word)))
      else $error("page not captured");
   a_rx_hold: assert property (@(posedge i_clock) disable iff (!i_rstn)
      !i_page_rx_valid |=> $stable(rx_r)) else $error("received word changed");
   a_flag_set: assert property (@(posedge i_clock) disable iff (!i_rstn)
      i_page_rx_valid |=> o_page_received) else $error("flag not set");
   a_flag_clear: assert property (@(posedge i_clock) disable iff (!i_rstn)
      (rd_exp && !i_page_rx_valid) |=> !o_page_received) else $error("flag not cleared");
   a_ready_arm: assert property (@(posedge i_clock) disable iff (!i_rstn)
      wr_tx |=> o_page_tx_ready) else $error("not armed");
   a_ready_drop: assert property (@(posedge i_clock) disable iff (!i_rstn)
      (i_page_tx_taken && !wr_tx) |=> !o_page_tx_ready) else $error("not disarmed");
   a_rsvd_read: assert property (@(posedge i_clock) disable iff (!i_rstn)
      (i_reg_rd && dec.sel == anpr_pkg::ANPR_SEL_NONE) |=> (o_reg_rdata == 16'h0000))
      else $error("reserved read not zero");
   a_ps_decode: assert property (@(posedge i_clock) disable iff (!i_rstn)
      (i_reg_addr == 5'h1A) |-> (o_ps_index == 3'h5)) else $error("bad decode");
endmodule // anpr_regs
`default_nettype wire

// file: tb/anpr_partner.sv
// Link partner model: delivers pages and consumes the outgoing word.
`timescale 1ns/1ps
`default_nettype none
module anpr_partner (
   input wire logic i_clock, // Clock.
   input wire logic i_rstn, // Reset, active low.
   input wire logic i_send, // Deliver a page.
   input wire logic [15:0] i_page, // Page to deliver.
   input wire logic i_slow, // Stall before taking.
   input wire logic [15:0] i_word, // Outgoing word.
   input wire logic i_ready, // Outgoing word pending.
   output logic o_valid, // Page strobe.
   output logic [15:0] o_rx, // Page word.
   output logic o_taken, // Word consumed.
   output logic [15:0] o_seen // Last word consumed.
);
   logic [3:0] wait_r;
   always_ff @(posedge i_clock or negedge i_rstn) begin
      if (!i_rstn) begin
         {o_valid, o_taken, wait_r, o_rx, o_seen} <= '0;
      end else begin
         o_valid <= i_send;
         // Off the strobe the word flips, so a stale capture cannot pass.
         o_rx <= i_send ? i_page : ~o_rx;
         o_taken <= 1'b0;
         if (i_ready && !o_taken) begin
            wait_r <= wait_r + 4'h1;
            if (wait_r >= (i_slow ? 4'h9 : 4'h0)) begin
               o_taken <= 1'b1;
               o_seen <= i_word;
               wait_r <= 4'h0;
            end
         end
      end
   end
endmodule // anpr_partner
`default_nettype wire

// file: tb/autoneg_next_page_regs_test.sv
// Self-checking bench for the next page register bank.
`timescale 1ns/1ps
`default_nettype none
module autoneg_next_page_regs_test;
   logic i_clock, i_rstn, i_reg_wr, i_reg_rd, i_send, i_slow, vld, tkn, rdy, pgr, pwr, prd;
   logic [4:0] i_reg_addr;
   logic [15:0] i_reg_wdata, i_ps_rdata, i_page, wrd, txw, rdd, seen, d;
   logic [2:0] idx;
   int bad_count, cmp_count, k;
   anpr_regs dut_u (.i_clock(i_clock), .i_rstn(i_rstn), .i_reg_addr(i_reg_addr),
      .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(rdd),
      .o_ps_wr(pwr), .o_ps_rd(prd), .o_ps_index(idx), .i_ps_rdata(i_ps_rdata),
      .i_page_rx_valid(vld), .i_page_rx_word(wrd), .i_page_tx_taken(tkn),
      .o_page_tx_word(txw), .o_page_tx_ready(rdy), .o_page_received(pgr));
   anpr_partner peer_u (.i_clock(i_clock), .i_rstn(i_rstn), .i_send(i_send), .i_page(i_page),
      .i_slow(i_slow), .i_word(txw), .i_ready(rdy), .o_valid(vld), .o_rx(wrd), .o_taken(tkn),
      .o_seen(seen));
   function automatic logic [2:0] ps_idx(input logic [4:0] a);
      case (a)
         5'h10, 5'h11, 5'h12, 5'h13, 5'h14: return 3'(a - 5'h10);
         5'h1A: return 3'h5;
         5'h1E: return 3'h6;
         default: return 3'h7;
      endcase
   endfunction
   task automatic chk(input string n, input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", n, exp, got);
      end
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic limit();
      if (k >= 40) begin
         bad_count++;
         results();
      end
   endtask
   task automatic access(input logic w, input logic [4:0] a, input logic [15:0] v);
      @(posedge i_clock);
      i_reg_addr <= a;
      i_reg_wdata <= v;
      i_reg_wr <= w;
      i_reg_rd <= !w;
      #1 chk("ps_strobe", {11'h0, pwr, prd, idx}, {11'h0, w && (ps_idx(a) != 3'h7),
         !w && (ps_idx(a) != 3'h7), ps_idx(a)});
      if (ps_idx(a) == 3'h7) chk("ps_none", {14'h0, pwr, prd}, 16'h0000);
      @(posedge i_clock);
      {i_reg_wr, i_reg_rd} <= 2'b00;
      #1;
   endtask
   task automatic rd(input logic [4:0] a, input logic [15:0] e);
      access(1'b0, a, 16'h0000);
      chk("rdata", rdd, e);
   endtask
   initial begin
      i_clock = 1'b0;
      forever #20 i_clock = ~i_clock;
   end
   initial begin
      {i_rstn, i_reg_wr, i_reg_rd, i_send, i_slow, i_reg_addr} = '0;
      {i_reg_wdata, i_ps_rdata, i_page} = '0;
      void'($urandom(81));
      repeat (16) @(posedge i_clock);
      i_rstn <= 1'b1;
      chk("tx_word", txw, 16'h2001);
      rd(5'h07, 16'h2001);
      rd(5'h08, 16'h0000);
      for (int i = 0; i < 10; i++) begin
         d = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : 16'($urandom);
         i_slow <= 1'($urandom);
         access(1'b1, 5'h07, d);
         chk("tx_ready", {txw, rdy}, {d & 16'hBFFF, 1'b1});
         rd(5'h07, d & 16'hBFFF);
      end
      for (k = 0; k < 40 && rdy !== 1'b0; k++) #40;
      limit();
      chk("seen", seen, d & 16'hBFFF);
      for (int a = 6; a < 32; a++) begin
         i_ps_rdata <= 16'($urandom);
         if (a != 7) access(1'b1, 5'(a), 16'hFFFF);
         if (a > 8) rd(5'(a), (ps_idx(5'(a)) == 3'h7) ? 16'h0000 : i_ps_rdata);
      end
      rd(5'h08, 16'h0000);
      chk("tx_kept", txw, d & 16'hBFFF);
      for (int i = 0; i < 4; i++) begin
         d = (i == 0) ? 16'hFFFF : 16'($urandom);
         @(posedge i_clock);
         i_page <= d;
         i_send <= 1'b1;
         @(posedge i_clock);
         i_send <= 1'b0;
         for (k = 0; k < 40 && pgr !== 1'b1; k++) #40;
         limit();
         rd(5'h08, d);
         rd(5'h06, 16'h0002);
         chk("page_flag", {15'h0, pgr}, 16'h0000);
         rd(5'h06, 16'h0000);
      end
      results();
   end
endmodule // autoneg_next_page_regs_test
`default_nettype wire
